// ### logic/plcr_params.svh
// Functional notes
// - with the enhanced link bit (bit 4) set the link indicator lights only for a 100 Mb/s full-duplex link, otherwise for any link.
// - while the enhanced link bit is set the activity-blink setting is ignored and the link indicator never blinks.
// - with the isolate bit (bit 3) set and a 100 Mb/s half-duplex link up, the MII outputs are isolated.
// - receive symbol errors during idle are flagged only while bit 2 is set, which resets to 1.
// - with bit 1 clear a transmit enable falling on an odd nibble is stretched one nibble with transmit error forced.
// - bit 0 set takes the RMII receive data timing from the receive clock, clear from the reference clock input.
// - polarity bit 6 at 1 is normal polarity, at 0 both twisted pairs are inverted.
// - crossover bit 5 set receives on the transmit pair and transmits on the receive pair.
// - port mirroring is on when bits 5 and 6 are both set.
// - fast-link-down bit 3 drops the link after 32 MII receive errors inside one 10 us interval.
// - fast-link-down bit 2 drops the link after 20 line-code violations inside one 10 us interval.
// - fast-link-down bit 1 drops the link after 20 low-SNR crossings inside one 10 us interval.
// - fast-link-down bit 0 drops the link as soon as the energy detector reports loss of energy.
// - the link drop is the OR of the four enabled conditions and the field resets to zero.
// - reserved bits 15 to 7 of the third control register ignore writes and read as zero.
`ifndef PLCR_PARAMS_SVH
`define PLCR_PARAMS_SVH

// ==========================================================
// register map
`define PLCR_ADDR_W 5
`define PLCR_DATA_W 16
`define PLCR_OFS_CTRL_TWO 5'h0a
`define PLCR_OFS_CTRL_THREE 5'h0b
`define PLCR_RST_CTRL_TWO 16'h0104
`define PLCR_RST_CTRL_THREE 16'h0000
`define PLCR_MASK_CTRL_THREE 16'h007f

// ==========================================================
// field positions, control two
`define PLCR_C2_ENH_LINK 4
`define PLCR_C2_ISOLATE 3
`define PLCR_C2_IDLE_ERR 2
`define PLCR_C2_ODD_DIS 1
`define PLCR_C2_RMII_RXCLK 0

// ==========================================================
// field positions, control three
`define PLCR_C3_POLARITY 6
`define PLCR_C3_CROSS 5
`define PLCR_C3_FLD_RXERR 3
`define PLCR_C3_FLD_MLT3 2
`define PLCR_C3_FLD_SNR 1
`define PLCR_C3_FLD_ENERGY 0

// ==========================================================
// timing
`define PLCR_CLK_MHZ 125
`define PLCR_WINDOW_NS 10000
`define PLCR_WINDOW_CYC ((`PLCR_WINDOW_NS * `PLCR_CLK_MHZ) / 1000)
`define PLCR_CNT_W 11
`define PLCR_THR_RXERR 32
`define PLCR_THR_MLT3 20
`define PLCR_THR_SNR 20
`define PLCR_EVT_CNT_W 6
`define PLCR_BLINK_W 22

`endif

// ### logic/plcr_pkg.sv
`default_nettype none

package plcr_pkg;

    // link state reported by the PCS/negotiation logic
    typedef struct packed {
        logic up;
        logic speed_100;
        logic full_duplex;
    } plcr_link_type;

    // one MII transmit nibble control pair
    typedef struct packed {
        logic en;
        logic er;
    } plcr_tx_ctl_type;

    // drop sources, one bit per monitor
    typedef struct packed {
        logic rx_err;
        logic mlt3_err;
        logic low_snr;
        logic energy_loss;
    } plcr_drop_type;

    typedef enum logic [1:0] {
        PLCR_TX_IDLE = 2'b00,
        PLCR_TX_EVEN = 2'b01,
        PLCR_TX_ODD = 2'b11,
        PLCR_TX_STRETCH = 2'b10
    } plcr_tx_state_type;

endpackage

`default_nettype wire

// ### logic/plcr_event_window.sv
`include "plcr_params.svh"
`default_nettype none

module plcr_event_window #(
    parameter logic [`PLCR_EVT_CNT_W-1:0] THRESHOLD = 6'h20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic enable,
    input wire logic interval_start,
    input wire logic event_in,
    // result
    output logic hit
);

    logic [`PLCR_EVT_CNT_W-1:0] count;
    logic [`PLCR_EVT_CNT_W-1:0] next_count;
    logic reached;

    // an event on the interval boundary counts toward the new interval
    assign next_count = interval_start ? {{(`PLCR_EVT_CNT_W-1){1'b0}}, event_in}
                      : (event_in && !reached) ? count + 6'h01 : count;
    assign reached = (count == THRESHOLD);

    always_ff @(posedge clk_sys) begin
        if (reset || !enable) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // hit stays up for the rest of the interval once the threshold is met
    assign hit = enable && reached;

endmodule

`default_nettype wire

// ### logic/plcr_link_ctrl.sv
`include "plcr_params.svh"
`default_nettype none

module plcr_link_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // management register port
    input wire logic [`PLCR_ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [`PLCR_DATA_W-1:0] reg_wdata,
    output logic [`PLCR_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // link state and indicator
    input wire plcr_pkg::plcr_link_type link_state,
    input wire logic activity,
    input wire logic phy_general_control_blink,
    output logic led_link,
    // receive side
    input wire logic rx_idle_symbol_error,
    output logic rx_idle_error,
    output logic mii_isolate,
    input wire logic rmii_rx_clk_tick,
    input wire logic reference_clock_input_tick,
    output logic rmii_ref_rx_clk,
    output logic rmii_rx_sample,
    // transmit side, one tick per transmit clock cycle
    input wire logic tx_clk_tick,
    input wire plcr_pkg::plcr_tx_ctl_type tx_mac,
    output plcr_pkg::plcr_tx_ctl_type tx_phy,
    // pair configuration
    output logic twisted_transmit_pair_invert,
    output logic twisted_receive_pair_invert,
    output logic pair_crossover,
    output logic port_mirror,
    // fast link down
    input wire logic rx_error_event,
    input wire logic mlt3_violation_event,
    input wire logic low_snr_event,
    input wire logic energy_loss,
    output plcr_pkg::plcr_drop_type drop_cause,
    output logic link_drop
);

    // ==========================================================
    // registers
    logic [`PLCR_DATA_W-1:0] link_control_two;
    logic [`PLCR_DATA_W-1:0] link_control_three;
    logic sel_two;
    logic sel_three;
    logic [`PLCR_DATA_W-1:0] next_rdata;

    assign sel_two = (reg_addr == `PLCR_OFS_CTRL_TWO);
    assign sel_three = (reg_addr == `PLCR_OFS_CTRL_THREE);

    // unmapped addresses read as zero; reserved bits are masked off
    assign next_rdata = sel_two ? link_control_two
                      : sel_three ? (link_control_three & `PLCR_MASK_CTRL_THREE)
                      : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            link_control_two <= `PLCR_RST_CTRL_TWO;
            link_control_three <= `PLCR_RST_CTRL_THREE;
        end else if (reg_write) begin
            if (sel_two) begin
                link_control_two <= reg_wdata;
            end
            if (sel_three) begin
                link_control_three <= reg_wdata & `PLCR_MASK_CTRL_THREE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? next_rdata : reg_rdata;
            reg_rvalid <= reg_read;
        end
    end

    // ==========================================================
    // field decode
    logic enh_link;
    logic isolate_hd;
    logic idle_err_en;
    logic odd_disable;
    logic rmii_rxclk;
    logic polarity_normal;
    logic crossover;
    logic [3:0] fld_enable;

    assign enh_link = link_control_two[`PLCR_C2_ENH_LINK];
    assign isolate_hd = link_control_two[`PLCR_C2_ISOLATE];
    assign idle_err_en = link_control_two[`PLCR_C2_IDLE_ERR];
    assign odd_disable = link_control_two[`PLCR_C2_ODD_DIS];
    assign rmii_rxclk = link_control_two[`PLCR_C2_RMII_RXCLK];
    assign polarity_normal = link_control_three[`PLCR_C3_POLARITY];
    assign crossover = link_control_three[`PLCR_C3_CROSS];
    assign fld_enable = link_control_three[`PLCR_C3_FLD_RXERR:`PLCR_C3_FLD_ENERGY];

    // ==========================================================
    // link indicator
    logic link_full_100;
    logic led_base;
    logic blink_allowed;
    logic [`PLCR_BLINK_W-1:0] blink_count;
    logic blink_phase;
    logic next_led;

    assign link_full_100 = link_state.up && link_state.speed_100 && link_state.full_duplex;
    assign led_base = enh_link ? link_full_100 : link_state.up;
    // the blink divider only runs while traffic is seen, so the led starts lit
    assign blink_allowed = phy_general_control_blink && !enh_link;
    assign blink_phase = blink_count[`PLCR_BLINK_W-1];
    assign next_led = led_base && !(blink_allowed && activity && blink_phase);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            blink_count <= '0;
        end else if (blink_allowed && activity) begin
            blink_count <= blink_count + 22'h000001;
        end else begin
            blink_count <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            led_link <= 1'b0;
        end else begin
            led_link <= next_led;
        end
    end

    // ==========================================================
    // receive side controls
    logic link_half_100;
    logic next_isolate;

    assign link_half_100 = link_state.up && link_state.speed_100 && !link_state.full_duplex;
    assign next_isolate = isolate_hd && link_half_100;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mii_isolate <= 1'b0;
            rx_idle_error <= 1'b0;
            rmii_ref_rx_clk <= 1'b0;
            rmii_rx_sample <= 1'b0;
        end else begin
            mii_isolate <= next_isolate;
            rx_idle_error <= idle_err_en && rx_idle_symbol_error;
            rmii_ref_rx_clk <= rmii_rxclk;
            rmii_rx_sample <= rmii_rxclk ? rmii_rx_clk_tick
                                         : reference_clock_input_tick;
        end
    end

    // ==========================================================
    // transmit odd-nibble handling
    plcr_pkg::plcr_tx_state_type tx_state;
    plcr_pkg::plcr_tx_state_type next_tx_state;
    plcr_pkg::plcr_tx_ctl_type next_tx;

    // parity counts nibbles sent since enable rose; odd means a byte is split
    always_comb begin
        next_tx_state = tx_state;
        next_tx = tx_phy;
        if (tx_clk_tick) begin
            unique case (tx_state)
                plcr_pkg::PLCR_TX_IDLE,
                plcr_pkg::PLCR_TX_STRETCH: begin
                    next_tx = tx_mac;
                    next_tx_state = tx_mac.en ? plcr_pkg::PLCR_TX_ODD
                                              : plcr_pkg::PLCR_TX_IDLE;
                end
                plcr_pkg::PLCR_TX_ODD: begin
                    if (tx_mac.en) begin
                        next_tx = tx_mac;
                        next_tx_state = plcr_pkg::PLCR_TX_EVEN;
                    end else if (!odd_disable) begin
                        next_tx.en = 1'b1;
                        next_tx.er = 1'b1;
                        next_tx_state = plcr_pkg::PLCR_TX_STRETCH;
                    end else begin
                        next_tx = tx_mac;
                        next_tx_state = plcr_pkg::PLCR_TX_IDLE;
                    end
                end
                plcr_pkg::PLCR_TX_EVEN: begin
                    next_tx = tx_mac;
                    next_tx_state = tx_mac.en ? plcr_pkg::PLCR_TX_ODD
                                              : plcr_pkg::PLCR_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_state <= plcr_pkg::PLCR_TX_IDLE;
            tx_phy <= '0;
        end else begin
            tx_state <= next_tx_state;
            tx_phy <= next_tx;
        end
    end

    // ==========================================================
    // pair configuration
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            twisted_transmit_pair_invert <= 1'b1;
            twisted_receive_pair_invert <= 1'b1;
            pair_crossover <= 1'b0;
            port_mirror <= 1'b0;
        end else begin
            twisted_transmit_pair_invert <= !polarity_normal;
            twisted_receive_pair_invert <= !polarity_normal;
            pair_crossover <= crossover;
            port_mirror <= crossover && polarity_normal;
        end
    end

    // ==========================================================
    // fast link down
    logic [`PLCR_CNT_W-1:0] interval_count;
    logic interval_start;
    logic hit_rx_err;
    logic hit_mlt3;
    logic hit_snr;
    plcr_pkg::plcr_drop_type next_cause;

    // one shared interval keeps the three monitors aligned to the same window
    assign interval_start = (interval_count == 11'(`PLCR_WINDOW_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            interval_count <= '0;
        end else if (interval_start) begin
            interval_count <= '0;
        end else begin
            interval_count <= interval_count + 11'h001;
        end
    end

    plcr_event_window #(
        .THRESHOLD(6'(`PLCR_THR_RXERR))
    ) u_win_rx_err (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(fld_enable[`PLCR_C3_FLD_RXERR]),
        .interval_start(interval_start),
        .event_in(rx_error_event),
        .hit(hit_rx_err)
    );

    plcr_event_window #(
        .THRESHOLD(6'(`PLCR_THR_MLT3))
    ) u_win_mlt3 (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(fld_enable[`PLCR_C3_FLD_MLT3]),
        .interval_start(interval_start),
        .event_in(mlt3_violation_event),
        .hit(hit_mlt3)
    );

    plcr_event_window #(
        .THRESHOLD(6'(`PLCR_THR_SNR))
    ) u_win_snr (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(fld_enable[`PLCR_C3_FLD_SNR]),
        .interval_start(interval_start),
        .event_in(low_snr_event),
        .hit(hit_snr)
    );

    assign next_cause.rx_err = hit_rx_err;
    assign next_cause.mlt3_err = hit_mlt3;
    assign next_cause.low_snr = hit_snr;
    // energy loss acts at once; the detector's own delay sets the reaction time
    assign next_cause.energy_loss = fld_enable[`PLCR_C3_FLD_ENERGY] && energy_loss;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drop_cause <= '0;
            link_drop <= 1'b0;
        end else begin
            drop_cause <= next_cause;
            link_drop <= |next_cause;
        end
    end

endmodule

`default_nettype wire

// ### verif/plcr_mac_model.sv
`default_nettype none

module plcr_mac_model (
    // clock
    input wire logic clk_sys,
    // bench control
    input wire logic start,
    input wire logic [3:0] nibbles,
    // transmit towards the block
    output logic tx_clk_tick,
    output plcr_pkg::plcr_tx_ctl_type tx_mac
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========
    // tick every fourth cycle, frame of a given nibble count
    logic [1:0] div = 2'h0;
    logic [3:0] left = 4'h0;
    logic go = 1'b0;

    // start is taken on the rising edge so that the bench and this model never race
    always @(posedge clk_sys) begin
        go <= start;
    end

    // the mac never raises transmit error, so any error seen comes from the block
    initial begin
        tx_clk_tick = 1'b0;
        tx_mac = '0;
    end

    always @(negedge clk_sys) begin
        div <= div + 2'h1;
        tx_clk_tick <= div == 2'h3;
        if (go) begin
            left <= nibbles;
        end else if (tx_clk_tick) begin
            tx_mac.en <= left != 4'h0;
            left <= (left != 4'h0) ? left - 4'h1 : 4'h0;
        end
    end
endmodule

`default_nettype wire

// ### verif/plcr_link_ctrl_props.sv
`include "plcr_params.svh"
`default_nettype none

module plcr_link_ctrl_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [`PLCR_ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [`PLCR_DATA_W-1:0] reg_wdata,
    input wire logic [`PLCR_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    // link and indicator
    input wire plcr_pkg::plcr_link_type link_state,
    input wire logic activity,
    input wire logic led_link,
    // receive side
    input wire logic rx_idle_symbol_error,
    input wire logic rx_idle_error,
    input wire logic mii_isolate,
    input wire logic rmii_ref_rx_clk,
    // pairs
    input wire logic twisted_transmit_pair_invert,
    input wire logic twisted_receive_pair_invert,
    input wire logic pair_crossover,
    input wire logic port_mirror,
    // fast link down
    input wire logic energy_loss,
    input wire plcr_pkg::plcr_drop_type drop_cause,
    input wire logic link_drop
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========
    // shadow registers rebuilt from the writes
    logic [15:0] c2;
    logic [15:0] c3;
    wire logic wr2 = reg_write && reg_addr == `PLCR_OFS_CTRL_TWO;
    wire logic wr3 = reg_write && reg_addr == `PLCR_OFS_CTRL_THREE;
    wire logic rd3 = reg_read && reg_addr == `PLCR_OFS_CTRL_THREE;
    wire logic fd100 = link_state == 3'b111;
    wire logic hd100 = link_state == 3'b110;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            c2 <= `PLCR_RST_CTRL_TWO;
            c3 <= `PLCR_RST_CTRL_THREE;
        end else begin
            if (wr2) begin
                c2 <= reg_wdata;
            end
            if (wr3) begin
                c3 <= reg_wdata & `PLCR_MASK_CTRL_THREE;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ========
    // assertions
    a_led_enh_dark: assert property (c2[4] && !fd100 |=> !led_link)
        else $error("link indicator lit outside full duplex 100");
    a_led_enh_lit: assert property (c2[4] && fd100 |=> led_link)
        else $error("link indicator dark or blinking on full duplex 100");
    a_led_any_link: assert property (!c2[4] && link_state.up && !activity |=> led_link)
        else $error("link indicator dark on an up link");
    a_isolate_hd: assert property (c2[3] && hd100 |=> mii_isolate)
        else $error("outputs not isolated on half duplex 100");
    a_isolate_off: assert property (!c2[3] |=> !mii_isolate)
        else $error("outputs isolated with isolate bit clear");
    a_idle_err_gate: assert property (rx_idle_symbol_error |=> rx_idle_error == $past(c2[2]))
        else $error("idle symbol error gating wrong");
    a_rmii_ref_sel: assert property (1 |=> rmii_ref_rx_clk == $past(c2[0]))
        else $error("rmii receive timing select wrong");
    a_pair_cfg: assert property (1 |=> {twisted_transmit_pair_invert,
        twisted_receive_pair_invert, pair_crossover, port_mirror} == {!$past(c3[6]),
        !$past(c3[6]), $past(c3[5]), $past(c3[5]) && $past(c3[6])})
        else $error("pair configuration outputs wrong");
    a_energy_drop: assert property (c3[0] && energy_loss [*3] |-> drop_cause.energy_loss)
        else $error("energy loss did not drop the link");
    a_drop_or: assert property (link_drop == |drop_cause)
        else $error("link drop is not the or of its causes");
    a_c3_reserved: assert property (rd3 |=> reg_rvalid && reg_rdata[15:7] == 9'h000)
        else $error("reserved bits of control three read nonzero");

    c_drop: cover property (link_drop);
    c_mirror: cover property (port_mirror);
    c_idle_err: cover property (rx_idle_error);
endmodule

bind plcr_link_ctrl plcr_link_ctrl_props plcr_link_ctrl_props_inst (
    .clk_sys, .reset, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .reg_rvalid, .link_state, .activity, .led_link, .rx_idle_symbol_error,
    .rx_idle_error, .mii_isolate, .rmii_ref_rx_clk, .twisted_transmit_pair_invert,
    .twisted_receive_pair_invert, .pair_crossover, .port_mirror, .energy_loss,
    .drop_cause, .link_drop
);

`default_nettype wire

// ### verif/tb_top.sv
`include "plcr_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [15:0] c2;
        logic [15:0] c3;
        logic [2:0] ln;
        logic act;
        logic [7:0] exp;
    } plcr_row_type;

    // expected: led, isolate, tx invert, rx invert, crossover, mirror, rmii ref, sample
    localparam plcr_row_type rows [6] = '{
        {16'h0000, 16'h0000, 3'b111, 1'b0, 8'hb0},
        {16'h0010, 16'h0040, 3'b110, 1'b0, 8'h00},
        {16'h0019, 16'h0020, 3'b110, 1'b0, 8'h7b},
        {16'h0011, 16'h0060, 3'b111, 1'b1, 8'h8f},
        {16'h0008, 16'h0060, 3'b100, 1'b0, 8'h8c},
        {16'h0000, 16'h0000, 3'b000, 1'b0, 8'h30}};
    localparam logic [15:0] txexp [3] = '{16'h1004, 16'h1000, 16'h0c00};

    logic clk_sys, reset, reg_write, reg_read, reg_rvalid, activity, led_link;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    plcr_pkg::plcr_link_type link_state;
    logic rx_idle_symbol_error, rx_idle_error, mii_isolate, rmii_ref_rx_clk, rmii_rx_sample;
    logic tx_clk_tick, start, energy_loss, link_drop, pair_crossover, port_mirror;
    logic twisted_transmit_pair_invert, twisted_receive_pair_invert;
    logic [3:0] nibbles, seen;
    logic [2:0] ev;
    plcr_pkg::plcr_tx_ctl_type tx_mac, tx_phy;
    plcr_pkg::plcr_drop_type drop_cause;
    int checks = 0, err_total = 0, en_n = 0, er_n = 0, thr;
    wire logic [7:0] outs = {led_link, mii_isolate, twisted_transmit_pair_invert,
        twisted_receive_pair_invert, pair_crossover, port_mirror, rmii_ref_rx_clk,
        rmii_rx_sample};

    plcr_link_ctrl plcr_link_ctrl_inst (
        .clk_sys, .reset, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
        .reg_rvalid, .link_state, .activity, .phy_general_control_blink(1'b1), .led_link,
        .rx_idle_symbol_error, .rx_idle_error, .mii_isolate, .rmii_rx_clk_tick(1'b1),
        .reference_clock_input_tick(1'b0), .rmii_ref_rx_clk, .rmii_rx_sample,
        .tx_clk_tick, .tx_mac, .tx_phy, .twisted_transmit_pair_invert,
        .twisted_receive_pair_invert, .pair_crossover, .port_mirror,
        .rx_error_event(ev[2]), .mlt3_violation_event(ev[1]), .low_snr_event(ev[0]),
        .energy_loss, .drop_cause, .link_drop);

    plcr_mac_model plcr_mac_model_inst (.clk_sys, .start, .nibbles, .tx_clk_tick, .tx_mac);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // sticky view of drop causes, so a hit cleared by an interval restart is still seen
    always @(posedge clk_sys) begin
        seen <= seen | drop_cause;
        en_n <= en_n + int'(tx_phy.en);
        er_n <= er_n + int'(tx_phy.er);
    end

    // ========
    // tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
    endtask

    task rd(input logic [4:0] a, input logic [15:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk_sys);
        reg_read = 1'b0;
        chk({reg_rvalid, reg_rdata}, {1'b1, e});
    endtask

    task burst(input int k, input logic [2:0] m);
        repeat (k) begin
            @(negedge clk_sys);
            ev = m;
        end
        @(negedge clk_sys);
        ev = 3'h0;
    endtask

    task done(input string n);
        $display("test %s done, mismatches so far %0d", n, err_total);
    endtask

    task final_report;
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ========
    // sequence
    initial begin
        {reset, reg_write, reg_read, activity, rx_idle_symbol_error, start} = 6'h20;
        {reg_addr, reg_wdata, nibbles, ev, energy_loss, seen} = '0;
        link_state = '0;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        foreach (rows[i]) begin
            wr(5'h0a, rows[i].c2);
            wr(5'h0b, rows[i].c3);
            link_state = rows[i].ln;
            activity = rows[i].act;
            repeat (3) @(negedge clk_sys);
            chk(outs, rows[i].exp);
            rd(5'h0a, rows[i].c2);
            rd(5'h0b, rows[i].c3 & `PLCR_MASK_CTRL_THREE);
        end
        done("rows");
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        chk({twisted_transmit_pair_invert, twisted_receive_pair_invert, link_drop}, 3'h6);
        rd(5'h0a, 16'h0104);
        rd(5'h0b, 16'h0000);
        wr(5'h0b, 16'hff80);
        rd(5'h0b, 16'h0000);
        rd(5'h1f, 16'h0000);
        done("reset and reserved");
        for (int i = 0; i < 2; i++) begin
            wr(5'h0a, (i == 0) ? 16'h0004 : 16'h0000);
            rx_idle_symbol_error = 1'b1;
            @(negedge clk_sys);
            rx_idle_symbol_error = 1'b0;
            chk(rx_idle_error, (i == 0) ? 1'b1 : 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(5'h0a, (i == 2) ? 16'h0002 : 16'h0000);
            {en_n, er_n} = '0;
            nibbles = (i == 1) ? 4'h4 : 4'h3;
            start = 1'b1;
            @(negedge clk_sys);
            start = 1'b0;
            repeat (40) @(negedge clk_sys);
            chk({en_n[7:0], er_n[7:0]}, txexp[i]);
        end
        done("idle error and odd nibble");
        for (int s = 0; s < 3; s++) begin
            wr(5'h0b, 16'h0008 >> s);
            thr = (s == 0) ? `PLCR_THR_RXERR : `PLCR_THR_MLT3;
            repeat (4) @(negedge clk_sys);
            seen = 4'h0;
            burst(thr - 1, 3'h4 >> s);
            repeat (1300) @(negedge clk_sys);
            burst(thr - 1, 3'h4 >> s);
            chk(seen, 4'h0);
            burst(2 * thr, 3'h4 >> s);
            repeat (3) @(negedge clk_sys);
            chk(seen, 4'h8 >> s);
        end
        wr(5'h0b, 16'h0000);
        repeat (4) @(negedge clk_sys);
        seen = 4'h0;
        energy_loss = 1'b1;
        burst(64, 3'h7);
        chk(seen, 4'h0);
        wr(5'h0b, 16'h0001);
        repeat (4) @(negedge clk_sys);
        chk({drop_cause, link_drop}, 5'h03);
        done("fast link down");
        final_report;
    end

    initial begin
        #200000;
        err_total++;
        final_report;
    end
endmodule

`default_nettype wire
